/* logic/opcode_class_exception_decode.sv */
// Registered primary opcode decoder with exception classification.
// Assumes fetch presents one word per cycle with a valid strobe and
// that privilege and coprocessor enables are stable with the word.
`timescale 1ns/1ps
`default_nettype none

module opcode_class_exception_decode
    import opdec_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic word_valid,
    input wire logic [31:0] word,
    input wire logic [1:0] arch_level,
    input wire logic legacy_two_mode,
    input wire logic fp_present,
    input wire logic fp_enable,
    input wire logic cop2_enable,
    input wire logic privileged,
    input wire logic sysctl_mem_used,
    input wire logic fp_wide_write,
    input wire logic fp_wide_value,
    output logic dec_valid,
    output op_sel_t op_sel,
    output logic [5:0] sub_field,
    output logic exc_reserved,
    output logic exc_cop_unusable,
    output logic [1:0] exc_cop_num,
    output logic fp_wide_regs
);

    // ------------------------------------------------------------
    // Register-width mode
    // ------------------------------------------------------------
    logic fp_wide_reg, fp_wide_next;

    // Writable only by privileged code on a present unit
    always_comb begin
        fp_wide_next = fp_wide_reg;
        if (fp_wide_write && privileged && fp_present) begin
            fp_wide_next = fp_wide_value;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fp_wide_reg <= FP_WIDE_RST;
        end else begin
            fp_wide_reg <= fp_wide_next;
        end
    end

    // ------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------
    logic valid_reg, valid_next;
    op_sel_t sel_reg, sel_next;
    logic [5:0] sub_reg, sub_next;
    logic rsv_reg, rsv_next;
    logic cpu_reg, cpu_next;
    logic [1:0] cnum_reg, cnum_next;
    logic [5:0] opc;
    logic [5:0] fn;
    logic fp_ok;

    assign opc = word[OPC_HI:OPC_LO];
    assign fn = word[FN_HI:FN_LO];
    // Absent unit behaves as permanently disabled
    assign fp_ok = fp_present && fp_enable;

    // Reserved wins over unusable so only one flag ever rises
    always_comb begin
        valid_next = word_valid;
        sel_next = op_execute;
        sub_next = 6'h00;
        rsv_next = 1'b0;
        cpu_next = 1'b0;
        cnum_next = 2'h0;
        case (opc)
            OPC_SPECIAL: begin
                sel_next = op_class_special;
                sub_next = fn;
                // Conditional moves arrived at level four
                if ((fn == FN_MOVE_FP_COND || fn == FN_MOVE_IF_ZERO ||
                     fn == FN_MOVE_IF_NONZERO) &&
                    arch_level != LVL_FOUR) begin
                    rsv_next = 1'b1;
                end else if (fn == FN_MOVE_FP_COND && !fp_ok) begin
                    cpu_next = 1'b1;
                    cnum_next = 2'h1;
                end
            end
            OPC_REG_IMM: begin
                sel_next = op_class_reg_imm;
                sub_next = {1'b0, word[RT_HI:RT_LO]};
            end
            OPC_FPCOP, OPC_FPX, OPC_LOAD_FP, OPC_STORE_FP,
            OPC_LOAD_FPD, OPC_STORE_FPD: begin
                // Routed as is; imprecise multiply-add is the unit's affair
                sel_next = op_fp_coprocessor;
                sub_next = word[25:20];
                if (!fp_ok) begin
                    cpu_next = 1'b1;
                    cnum_next = 2'h1;
                end
            end
            OPC_SYSCTL: begin
                sel_next = op_system_control;
                if (!privileged) begin
                    cpu_next = 1'b1;
                end
            end
            OPC_COP2: begin
                sel_next = op_none;
                if (!cop2_enable) begin
                    cpu_next = 1'b1;
                    cnum_next = 2'h2;
                end
            end
            OPC_SYSCTL_LD, OPC_SYSCTL_ST: begin
                sel_next = op_system_control;
                if (!sysctl_mem_used) begin
                    rsv_next = 1'b1;
                end else if (!privileged) begin
                    cpu_next = 1'b1;
                end
            end
            OPC_RSV_TRAP0: begin
                rsv_next = 1'b1;
            end
            OPC_RSV_UNDEF0: begin
                // Trapping is the safe choice for undefined slots
                rsv_next = 1'b1;
            end
            OPC_LEGACY0, OPC_LEGACY1: begin
                if (arch_level >= LVL_THREE && legacy_two_mode) begin
                    rsv_next = 1'b1;
                end
            end
            default: begin
                sel_next = op_execute;
            end
        endcase
        // Any exception suppresses the operation
        if (rsv_next || cpu_next) begin
            sel_next = op_none;
            cpu_next = cpu_next && !rsv_next;
        end
        if (!word_valid) begin
            sel_next = op_none;
            rsv_next = 1'b0;
            cpu_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            valid_reg <= 1'b0;
            sel_reg <= op_none;
            sub_reg <= 6'h00;
            rsv_reg <= 1'b0;
            cpu_reg <= 1'b0;
            cnum_reg <= 2'h0;
        end else begin
            valid_reg <= valid_next;
            sel_reg <= sel_next;
            sub_reg <= sub_next;
            rsv_reg <= rsv_next;
            cpu_reg <= cpu_next;
            cnum_reg <= cnum_next;
        end
    end

    assign dec_valid = valid_reg;
    assign op_sel = sel_reg;
    assign sub_field = sub_reg;
    assign exc_reserved = rsv_reg;
    assign exc_cop_unusable = cpu_reg;
    assign exc_cop_num = cnum_reg;
    assign fp_wide_regs = fp_wide_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_one_exception: assert property (@(posedge mclk) disable iff (!resetn)
        !(exc_reserved && exc_cop_unusable))
        else $error("two exceptions on one word");
    chk_trap_slot: assert property (@(posedge mclk) disable iff (!resetn)
        word_valid && opc == OPC_RSV_TRAP0 |=> exc_reserved)
        else $error("reserved trap slot missed");
    chk_undef_slot: assert property (@(posedge mclk) disable iff (!resetn)
        word_valid && opc == OPC_RSV_UNDEF0 |=> exc_reserved)
        else $error("undefined slot did not trap");
    chk_class_decode: assert property (@(posedge mclk) disable iff (!resetn)
        word_valid && opc == OPC_REG_IMM |=>
        op_sel == op_class_reg_imm &&
        sub_field == {1'b0, $past(word[RT_HI:RT_LO])})
        else $error("class opcode not decoded further");
    chk_fp_disabled: assert property (@(posedge mclk) disable iff (!resetn)
        word_valid && opc == OPC_FPCOP && !fp_enable |=>
        exc_cop_unusable && exc_cop_num == 2'h1 && op_sel == op_none)
        else $error("disabled floating op not blocked");
    chk_sysctl_priv: assert property (@(posedge mclk) disable iff (!resetn)
        word_valid && opc == OPC_SYSCTL && !privileged |=>
        exc_cop_unusable)
        else $error("system control without privilege");
    chk_fp_class: assert property (@(posedge mclk) disable iff (!resetn)
        word_valid && opc == OPC_FPX && fp_ok |=>
        op_sel == op_fp_coprocessor && !exc_cop_unusable)
        else $error("floating class wrongly refused");
    chk_sysctl_mem: assert property (@(posedge mclk) disable iff (!resetn)
        word_valid && opc == OPC_SYSCTL_LD && !sysctl_mem_used |=>
        exc_reserved)
        else $error("unused base-offset slot not reserved");
    chk_legacy: assert property (@(posedge mclk) disable iff (!resetn)
        word_valid && opc == OPC_LEGACY0 && legacy_two_mode &&
        arch_level == LVL_FOUR |=> exc_reserved)
        else $error("removed opcode ran in legacy mode");
    chk_wide_mode: assert property (@(posedge mclk) disable iff (!resetn)
        fp_wide_write && !privileged |=> $stable(fp_wide_regs))
        else $error("width mode changed without privilege");

endmodule

`default_nettype wire

/* common/opdec_pkg.sv */
// Shared constants and types for the opcode class decoder.
// Assumes a 32-bit instruction word with the opcode in the top six bits.
package opdec_pkg;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int RT_HI = 20;
    localparam int RT_LO = 16;
    localparam int FN_HI = 5;
    localparam int FN_LO = 0;

    // ------------------------------------------------------------
    // Primary opcode values
    // ------------------------------------------------------------
    localparam logic [5:0] OPC_SPECIAL = 6'h00;
    localparam logic [5:0] OPC_REG_IMM = 6'h01;
    localparam logic [5:0] OPC_SYSCTL = 6'h10;
    localparam logic [5:0] OPC_FPCOP = 6'h11;
    localparam logic [5:0] OPC_COP2 = 6'h12;
    localparam logic [5:0] OPC_FPX = 6'h13;
    localparam logic [5:0] OPC_LOAD_FP = 6'h31;
    localparam logic [5:0] OPC_LOAD_FPD = 6'h35;
    localparam logic [5:0] OPC_STORE_FP = 6'h39;
    localparam logic [5:0] OPC_STORE_FPD = 6'h3d;
    localparam logic [5:0] OPC_SYSCTL_LD = 6'h33;
    localparam logic [5:0] OPC_SYSCTL_ST = 6'h3b;
    localparam logic [5:0] OPC_RSV_TRAP0 = 6'h1c;
    localparam logic [5:0] OPC_RSV_UNDEF0 = 6'h1d;
    localparam logic [5:0] OPC_LEGACY0 = 6'h32;
    localparam logic [5:0] OPC_LEGACY1 = 6'h3a;

    // Function field values inside the special class
    localparam logic [5:0] FN_MOVE_FP_COND = 6'h01;
    localparam logic [5:0] FN_MOVE_IF_ZERO = 6'h0a;
    localparam logic [5:0] FN_MOVE_IF_NONZERO = 6'h0b;

    // Architecture levels, inclusive
    localparam logic [1:0] LVL_ONE = 2'h0;
    localparam logic [1:0] LVL_TWO = 2'h1;
    localparam logic [1:0] LVL_THREE = 2'h2;
    localparam logic [1:0] LVL_FOUR = 2'h3;

    // Reset values
    localparam logic FP_WIDE_RST = 1'b0;

    typedef enum logic [2:0] {
        op_execute,
        op_class_special,
        op_class_reg_imm,
        op_fp_coprocessor,
        op_system_control,
        op_none
    } op_sel_t;

endpackage

/* testbench/opcode_class_exception_decode_bench.sv */
// Self-checking bench for the opcode class decoder.
// Assumes latency one from a taken word to the registered outputs.
`timescale 1ns/1ps
`default_nettype none
module opcode_class_exception_decode_bench;
    import opdec_pkg::*;
    logic mclk = 0, resetn = 0, word_valid = 0;
    logic [31:0] word = 32'h0;
    logic [1:0] arch_level = LVL_FOUR;
    logic legacy_two_mode = 0, fp_present = 1, fp_enable = 1;
    logic cop2_enable = 1, privileged = 1, sysctl_mem_used = 1;
    logic fp_wide_write = 0, fp_wide_value = 0;
    logic dec_valid, exc_reserved, exc_cop_unusable, fp_wide_regs;
    op_sel_t op_sel;
    logic [5:0] sub_field;
    logic [1:0] exc_cop_num;
    int n_errors = 0, tests_run = 0;

    opcode_class_exception_decode i_opcode_class_exception_decode (
        .mclk(mclk), .resetn(resetn), .word_valid(word_valid),
        .word(word), .arch_level(arch_level),
        .legacy_two_mode(legacy_two_mode), .fp_present(fp_present),
        .fp_enable(fp_enable), .cop2_enable(cop2_enable),
        .privileged(privileged), .sysctl_mem_used(sysctl_mem_used),
        .fp_wide_write(fp_wide_write), .fp_wide_value(fp_wide_value),
        .dec_valid(dec_valid), .op_sel(op_sel), .sub_field(sub_field),
        .exc_reserved(exc_reserved), .exc_cop_unusable(exc_cop_unusable),
        .exc_cop_num(exc_cop_num), .fp_wide_regs(fp_wide_regs));

    // ------------------------------------------------------------
    // Clock, comparisons and the single exit point
    // ------------------------------------------------------------
    always #5 mclk = ~mclk;

    task automatic chk_val(input logic [5:0] got, input logic [5:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_sel(input op_sel_t got, input op_sel_t exp);
        chk_val({3'h0, got}, {3'h0, exp});
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One word through the decoder; flags are checked together so a
    // word never shows two exceptions at once
    task automatic dec(input logic [31:0] w, input logic res,
                       input logic unu, input logic [1:0] num,
                       input op_sel_t sel);
        @(posedge mclk);
        word_valid <= 1'b1;
        word <= w;
        @(posedge mclk);
        #1;
        chk_val({5'h0, dec_valid}, 6'h01);
        chk_val({5'h0, exc_reserved}, {5'h0, res});
        chk_val({5'h0, exc_cop_unusable}, {5'h0, unu});
        chk_sel(op_sel, sel);
        if (unu) chk_val({4'h0, exc_cop_num}, {4'h0, num});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reserved();
        dec({6'h1c, 26'h0}, 1, 0, 0, op_none);
        dec({6'h1d, 26'h0}, 1, 0, 0, op_none);
        dec({6'h1c, 26'h3ffffff}, 1, 0, 0, op_none);
        $display("reserved slots done");
    endtask

    task automatic t_classes();
        dec({6'h00, 20'h0, FN_MOVE_IF_ZERO}, 0, 0, 0, op_class_special);
        chk_val(sub_field, FN_MOVE_IF_ZERO);
        dec({6'h00, 20'h0, FN_MOVE_FP_COND}, 0, 0, 0, op_class_special);
        chk_val(sub_field, FN_MOVE_FP_COND);
        dec({6'h01, 5'h0, 5'h11, 16'h0}, 0, 0, 0, op_class_reg_imm);
        chk_val(sub_field, 6'h11);
        dec({6'h08, 26'h0}, 0, 0, 0, op_execute);
        // Level-four class members are refused one level down
        @(posedge mclk);
        arch_level <= LVL_THREE;
        dec({6'h00, 20'h0, FN_MOVE_IF_NONZERO}, 1, 0, 0, op_none);
        @(posedge mclk);
        arch_level <= LVL_FOUR;
        $display("class decode done");
    endtask

    task automatic t_coproc();
        logic [5:0] fp_ops [6];
        fp_ops = '{6'h11, 6'h13, 6'h31, 6'h35, 6'h39, 6'h3d};
        @(posedge mclk);
        fp_enable <= 1'b0;
        foreach (fp_ops[i])
            dec({fp_ops[i], 26'h0}, 0, 1, 2'h1, op_none);
        @(posedge mclk);
        fp_enable <= 1'b1;
        cop2_enable <= 1'b0;
        dec({6'h11, 26'h0}, 0, 0, 0, op_fp_coprocessor);
        dec({6'h12, 26'h0}, 0, 1, 2'h2, op_none);
        dec({6'h13, 26'h0}, 0, 0, 0, op_fp_coprocessor);
        // An absent unit refuses its opcodes and its width mode
        @(posedge mclk);
        cop2_enable <= 1'b1;
        fp_present <= 1'b0;
        dec({6'h11, 26'h0}, 0, 1, 2'h1, op_none);
        wide(1, 1, 0);
        @(posedge mclk);
        fp_present <= 1'b1;
        $display("coprocessor access done");
    endtask

    task automatic t_sysctl();
        @(posedge mclk);
        privileged <= 1'b0;
        dec({6'h10, 26'h0}, 0, 1, 2'h0, op_none);
        dec({6'h33, 26'h0}, 0, 1, 2'h0, op_none);
        dec({6'h3b, 26'h0}, 0, 1, 2'h0, op_none);
        @(posedge mclk);
        sysctl_mem_used <= 1'b0;
        dec({6'h33, 26'h0}, 1, 0, 0, op_none);
        @(posedge mclk);
        sysctl_mem_used <= 1'b1;
        privileged <= 1'b1;
        dec({6'h3b, 26'h0}, 0, 0, 0, op_system_control);
        dec({6'h10, 26'h0}, 0, 0, 0, op_system_control);
        $display("system slots done");
    endtask

    task automatic t_legacy();
        @(posedge mclk);
        arch_level <= LVL_THREE;
        legacy_two_mode <= 1'b1;
        dec({6'h32, 26'h0}, 1, 0, 0, op_none);
        dec({6'h3a, 26'h0}, 1, 0, 0, op_none);
        @(posedge mclk);
        arch_level <= LVL_FOUR;
        dec({6'h32, 26'h0}, 1, 0, 0, op_none);
        @(posedge mclk);
        legacy_two_mode <= 1'b0;
        dec({6'h3a, 26'h0}, 0, 0, 0, op_execute);
        $display("legacy mode done");
    endtask

    // Reset in mid-run clears the width mode and the decode outputs
    task automatic t_reset();
        wide(1, 1, 1);
        @(posedge mclk);
        word_valid <= 1'b1;
        word <= {6'h1c, 26'h0};
        resetn <= 1'b0;
        #1;
        chk_val({5'h0, fp_wide_regs}, {5'h0, FP_WIDE_RST});
        chk_val({5'h0, dec_valid}, 6'h00);
        chk_val({5'h0, exc_reserved}, 6'h00);
        chk_sel(op_sel, op_none);
        @(posedge mclk);
        resetn <= 1'b1;
        word_valid <= 1'b0;
        $display("mid-run reset done");
    endtask

    // Width mode write; an unprivileged attempt must leave it alone
    task automatic wide(input logic p, input logic v, input logic exp);
        @(posedge mclk);
        privileged <= p;
        fp_wide_write <= 1'b1;
        fp_wide_value <= v;
        @(posedge mclk);
        fp_wide_write <= 1'b0;
        privileged <= 1'b1;
        #1;
        chk_val({5'h0, fp_wide_regs}, {5'h0, exp});
    endtask

    task automatic t_width();
        chk_val({5'h0, fp_wide_regs}, {5'h0, FP_WIDE_RST});
        wide(0, 1, 0);
        wide(1, 1, 1);
        wide(1, 0, 0);
        $display("register width mode done");
    endtask

    task automatic t_idle();
        // A trap opcode without its strobe must raise nothing
        @(posedge mclk);
        word_valid <= 1'b0;
        word <= {6'h1c, 26'h0};
        @(posedge mclk);
        #1;
        chk_val({5'h0, dec_valid}, 6'h00);
        chk_val({5'h0, exc_reserved}, 6'h00);
        chk_sel(op_sel, op_none);
        $display("idle cycle done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        t_width();
        t_reserved();
        t_classes();
        t_coproc();
        t_sysctl();
        t_legacy();
        t_reset();
        t_idle();
        finish_test();
    end

    // Whole run is about a hundred cycles; five hundred is ample
    initial begin
        #5000;
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
